// *** pkg/dtvf_pkg.sv ***
// Shared constants and types for the transfer vector fetch block.
// Assumes a 32-bit internal bus and 16-bit vector table entries.
`default_nettype none

package dtvf_pkg;

	// ************************************************************
	// Source table
	// ************************************************************
	localparam int NUM_HW_SRC = 33; // Hardware sources, table order
	localparam int NUM_SRC = 34; // Plus software, lowest priority
	localparam int SRC_IDX_W = 6; // Width of a source index

	// ************************************************************
	// Vector table and transfer information layout
	// ************************************************************
	localparam logic [31:0] VEC_BASE = 32'h0000_0400; // First entry
	localparam logic [31:0] VEC_LAST = 32'h0000_0440; // Last hardware entry
	localparam logic [31:0] INFO_OFF_HEAD = 32'h0000_0000; // Mode word, count
	localparam logic [31:0] INFO_OFF_THIRD = 32'h0000_0004; // Empty/initial/length
	localparam logic [31:0] INFO_OFF_SRC = 32'h0000_0008; // Source address
	localparam logic [31:0] INFO_OFF_DST = 32'h0000_000C; // Destination address

	// ************************************************************
	// Mode word fields
	// ************************************************************
	localparam int MODE_SIZE_LSB = 0; // Transfer unit size
	localparam int MODE_SMODE_LSB = 2; // Source step mode
	localparam int MODE_DMODE_LSB = 4; // Destination step mode
	localparam int MODE_XMODE_LSB = 6; // Transfer mode
	localparam int MODE_ISEL_BIT = 8; // Interrupt select
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;
	localparam logic [1:0] STEP_FIXED = 2'h0;
	localparam logic [1:0] STEP_INC = 2'h1;
	localparam logic [1:0] STEP_DEC = 2'h2;
	localparam logic [1:0] XMODE_NORMAL = 2'h0;
	localparam logic [1:0] XMODE_REPEAT = 2'h1;
	localparam logic [1:0] XMODE_BLOCK = 2'h2;

	// ************************************************************
	// Register map and fields
	// ************************************************************
	localparam logic [7:0] REG_ENA_LO = 8'h00; // Enables, sources 0..31
	localparam logic [7:0] REG_ENA_HI = 8'h04; // Enable, source 32
	localparam logic [7:0] REG_SWCTL = 8'h08; // Software control/status
	localparam logic [7:0] REG_BASE = 8'h0C; // Info base register
	localparam logic [7:0] REG_STAT = 8'h10; // Engine status
	localparam int SWCTL_EN_BIT = 8; // Software activation enable
	localparam int SWCTL_AE_BIT = 9; // Address error flag
	localparam int STAT_BUSY_BIT = 0; // Engine busy
	localparam int STAT_IDX_LSB = 8; // Source in service
	localparam logic [32:0] ENA_RST = 33'h0_0000_0000;
	localparam logic [7:0] SWVEC_RST = 8'h00;
	localparam logic [15:0] BASE_RST = 16'h0000;

	// Engine states
	typedef enum logic [3:0] {
		ST_IDLE, ST_VEC, ST_INF0, ST_INF1, ST_INF2, ST_INF3,
		ST_DRD, ST_DWR, ST_WB0, ST_WB2, ST_WB3, ST_DONE
	} dtvf_state_t;

endpackage

`default_nettype wire

// *** design/dtvf_prio_pick.sv ***
// Fixed priority picker: lowest request index wins.
// Assumes requests are same-clock levels; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module dtvf_prio_pick #(
	parameter int WIDTH = 34,
	parameter int IDX_W = 6
) (
	input wire logic [WIDTH-1:0] req,
	output logic valid,
	output logic [IDX_W-1:0] idx
);

	// ************************************************************
	// Priority scan
	// ************************************************************
	// Walk from the bottom of the table up so index 0 is taken last
	always_comb begin
		valid = |req;
		idx = '0;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = IDX_W'(i);
			end
		end
	end

endmodule

`default_nettype wire

// *** design/dtvf_top.sv ***
// Vector fetch and normal-mode transfer engine of the transfer controller.
// Assumes a single-clock memory bus with a one-cycle acknowledge pulse,
// and interrupt sources that are levels on the same clock.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Two-byte vector entry per source, low address
// R2: Software vector address is H'0400 plus field
// R3: Read vector first, then transfer information
// R4: Information start address must be four-aligned
// R5: Info address is base high, vector low
// R6: Hardware entries H'0400..H'0440, each enable-gated
// R7: Software never targets transfer controller registers
// R8: Normal order: mode, count, empty, source, destination
// R9: Repeat order: mode, count, initial, source, destination
// R10: Block order: mode, count, empty, length, addresses
// R11: Keep transfer information in dedicated RAM
// R12: Normal mode moves one unit per activation
// R13: Count 1 to 65536, zero means 65536
// R14: Interrupt CPU when count-one transfer completes
// R15: Write back mode, count minus one, addresses
// R16: Simultaneous requests served by table priority
// R17: Disabled source goes to CPU as interrupt
// R18: Interrupt select: every transfer or only last
// R19: Passing interrupt clears that source's enable; the software enable stays set then and drops only when none passes
// R20: Address step equals transfer unit size
// R21: Empty bytes ignored and never rewritten
module dtvf_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire logic [dtvf_pkg::NUM_HW_SRC-1:0] srcReq,
	output logic [dtvf_pkg::NUM_HW_SRC-1:0] cpuIrq,
	output logic swIrq,
	output logic memReq,
	output logic memWr,
	output logic [31:0] memAddr,
	output logic [1:0] memSize,
	output logic [31:0] memWdata,
	input wire logic [31:0] memRdata,
	input wire logic memAck,
	output logic busy
);
	localparam int NHW = dtvf_pkg::NUM_HW_SRC; // Hardware source count
	localparam int IW = dtvf_pkg::SRC_IDX_W; // Source index width
	// One-hot mask over all sources, software included
	function automatic logic [NHW:0] src_mask(input logic [IW-1:0] idx);
		src_mask = {{NHW{1'b0}}, 1'b1} << idx;
	endfunction

	// Step an address by one unit in the chosen direction
	function automatic logic [31:0] step_addr(input logic [31:0] addr,
		input logic [1:0] mode, input logic [31:0] step);
		case (mode)
			dtvf_pkg::STEP_INC: step_addr = addr + step;
			dtvf_pkg::STEP_DEC: step_addr = addr - step;
			default: step_addr = addr;
		endcase
	endfunction
	// ************************************************************
	// State
	// ************************************************************
	dtvf_pkg::dtvf_state_t state_reg, state_next; // Engine sequencer
	logic [NHW-1:0] enable_reg, enable_next; // Activation enable bits
	logic [7:0] swVec_reg, swVec_next; // Software vector field
	logic swEn_reg, swEn_next; // Software activation enable
	logic addrErr_reg, addrErr_next; // Misaligned info start seen
	logic [15:0] infoBase_reg; // Info base register
	logic [NHW:0] pend_reg, pend_next; // Accepted activations
	logic [IW-1:0] cur_reg; // Source in service
	logic [15:0] vecEntry_reg; // Fetched vector entry
	logic [15:0] mode_reg; // Mode word
	logic [15:0] count_reg; // Transfer count
	logic [31:0] srcAddr_reg; // Source address
	logic [31:0] dstAddr_reg; // Destination address
	logic [31:0] data_reg; // Unit being moved
	logic [31:0] regRdata_reg; // Read data, one cycle
	logic [NHW-1:0] cpuIrq_reg; // Interrupts to the CPU
	logic swIrq_reg; // Software activation interrupt
	logic memReq_reg, memWr_reg; // Bus request and direction
	logic [31:0] memAddr_reg, memWdata_reg; // Bus address and data
	logic [1:0] memSize_reg; // Bus access size
	logic busy_reg; // Engine not idle
	// ************************************************************
	// Decode
	// ************************************************************
	wire grantValid; // Some activation is pending
	wire [IW-1:0] grantIdx; // Highest priority pending source
	wire curIsSw = (cur_reg == IW'(NHW)); // Software activation in service
	wire [1:0] modeSize = mode_reg[dtvf_pkg::MODE_SIZE_LSB +: 2];
	wire [1:0] modeSrc = mode_reg[dtvf_pkg::MODE_SMODE_LSB +: 2];
	wire [1:0] modeDst = mode_reg[dtvf_pkg::MODE_DMODE_LSB +: 2];
	wire modeIsel = mode_reg[dtvf_pkg::MODE_ISEL_BIT];
	wire [31:0] unitStep = 32'h0000_0001 << modeSize; // [R20]
	// Each hardware source owns the next two-byte entry
	wire [31:0] hwVecAddr = dtvf_pkg::VEC_BASE + ({26'h000_0000, cur_reg} << 1); // [R1] [R6]
	wire [31:0] swVecAddr = dtvf_pkg::VEC_BASE + {24'h00_0000, swVec_reg}; // [R2]
	wire [31:0] vecAddr = curIsSw ? swVecAddr : hwVecAddr;
	wire [31:0] infoAddr = {infoBase_reg, vecEntry_reg}; // [R5]
	wire [31:0] srcNext = step_addr(srcAddr_reg, modeSrc, unitStep); // [R15] [R20]
	wire [31:0] dstNext = step_addr(dstAddr_reg, modeDst, unitStep); // [R15] [R20]
	// Count zero wraps to H'FFFF, which is how 65536 transfers work
	wire [15:0] countDec = count_reg - 16'h0001; // [R13]
	wire lastXfer = (count_reg == 16'h0001); // [R14]
	wire passIrq = modeIsel | lastXfer; // [R18]
	wire inDone = (state_reg == dtvf_pkg::ST_DONE);
	wire doneHw = inDone && !curIsSw;
	wire doneSw = inDone && curIsSw;
	wire [NHW:0] passMask = (doneHw && passIrq) ? src_mask(cur_reg) : '0; // [R19]
	wire grantTake = (state_reg == dtvf_pkg::ST_IDLE) && grantValid;
	wire issue = (state_reg != dtvf_pkg::ST_IDLE) && !inDone && !memReq_reg; // Bus-owning states
	wire vecBad = (memRdata[1:0] != 2'h0); // Unsupported start address [R4]
	wire wrLo = regWr && (regAddr == dtvf_pkg::REG_ENA_LO);
	wire wrHi = regWr && (regAddr == dtvf_pkg::REG_ENA_HI);
	wire wrSw = regWr && (regAddr == dtvf_pkg::REG_SWCTL);
	wire wrBase = regWr && (regAddr == dtvf_pkg::REG_BASE);
	wire swStart = wrSw && regWdata[dtvf_pkg::SWCTL_EN_BIT] && !swEn_reg;
	wire [NHW-1:0] enaWritten = {wrHi ? regWdata[0] : enable_reg[NHW-1],
		wrLo ? regWdata : enable_reg[NHW-2:0]};
	// Software sits above the last hardware source, so it loses ties
	dtvf_prio_pick #(
		.WIDTH(dtvf_pkg::NUM_SRC),
		.IDX_W(IW)
	) u_pick (
		.req(pend_reg & {(NHW + 1){!addrErr_reg}}), // [R16]
		.valid(grantValid),
		.idx(grantIdx)
	);
	// Hardware clear applied after the write so a pass never leaves it set
	assign enable_next = enaWritten & ~passMask[NHW-1:0]; // [R19]
	// An arriving request beats the clear of its own pending bit
	assign pend_next = (pend_reg & ~(grantTake ? src_mask(grantIdx) : '0))
		| ({swStart, srcReq & enable_reg} & {(NHW + 1){!addrErr_reg}}); // [R17]
	assign swVec_next = (wrSw && !swEn_reg) ? {regWdata[7:1], 1'b0} : swVec_reg;
	// Writing one always wins; without an interrupt the enable drops
	assign swEn_next = wrSw ? regWdata[dtvf_pkg::SWCTL_EN_BIT]
		: ((doneSw && !passIrq) ? 1'b0 : swEn_reg); // [R18]
	// Error set wins over a software clear in the same cycle
	assign addrErr_next = ((state_reg == dtvf_pkg::ST_VEC) && memAck && vecBad)
		| (addrErr_reg && !(wrSw && !regWdata[dtvf_pkg::SWCTL_AE_BIT]));
	// ************************************************************
	// Sequencer
	// ************************************************************
	// Vector, then four info longwords, one unit, three write-backs
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			dtvf_pkg::ST_IDLE: if (grantValid) state_next = dtvf_pkg::ST_VEC;
			dtvf_pkg::ST_VEC: if (memAck) begin // [R3]
				state_next = vecBad ? dtvf_pkg::ST_IDLE : dtvf_pkg::ST_INF0;
			end
			dtvf_pkg::ST_INF0: if (memAck) state_next = dtvf_pkg::ST_INF1;
			dtvf_pkg::ST_INF1: if (memAck) state_next = dtvf_pkg::ST_INF2;
			dtvf_pkg::ST_INF2: if (memAck) state_next = dtvf_pkg::ST_INF3;
			dtvf_pkg::ST_INF3: if (memAck) state_next = dtvf_pkg::ST_DRD;
			dtvf_pkg::ST_DRD: if (memAck) state_next = dtvf_pkg::ST_DWR;
			dtvf_pkg::ST_DWR: if (memAck) state_next = dtvf_pkg::ST_WB0;
			// Third longword is skipped: empty bytes stay as they were
			dtvf_pkg::ST_WB0: if (memAck) state_next = dtvf_pkg::ST_WB2; // [R21]
			dtvf_pkg::ST_WB2: if (memAck) state_next = dtvf_pkg::ST_WB3;
			dtvf_pkg::ST_WB3: if (memAck) state_next = dtvf_pkg::ST_DONE;
			dtvf_pkg::ST_DONE: state_next = dtvf_pkg::ST_IDLE;
			default: state_next = dtvf_pkg::ST_IDLE;
		endcase
	end
	// Bus fields for the transaction the current state owns
	logic [31:0] busAddr, busWdata; // Address and data to issue
	logic [1:0] busSize; // Access size to issue
	logic busWr; // Write when high
	always_comb begin
		busAddr = infoAddr;
		busWdata = 32'h0000_0000;
		busSize = dtvf_pkg::SIZE_LONG;
		busWr = 1'b0;
		case (state_reg)
			dtvf_pkg::ST_VEC: begin
				busAddr = vecAddr;
				busSize = dtvf_pkg::SIZE_WORD;
			end
			// Same offsets serve all modes, read in layout order
			dtvf_pkg::ST_INF0: busAddr = infoAddr + dtvf_pkg::INFO_OFF_HEAD; // [R8]
			dtvf_pkg::ST_INF1: busAddr = infoAddr + dtvf_pkg::INFO_OFF_THIRD; // [R9] [R10]
			dtvf_pkg::ST_INF2: busAddr = infoAddr + dtvf_pkg::INFO_OFF_SRC;
			dtvf_pkg::ST_INF3: busAddr = infoAddr + dtvf_pkg::INFO_OFF_DST;
			dtvf_pkg::ST_DRD: begin // [R12]
				busAddr = srcAddr_reg;
				busSize = modeSize;
			end
			dtvf_pkg::ST_DWR: begin
				busAddr = dstAddr_reg;
				busSize = modeSize;
				busWdata = data_reg;
				busWr = 1'b1;
			end
			dtvf_pkg::ST_WB0: begin // [R15]
				busAddr = infoAddr + dtvf_pkg::INFO_OFF_HEAD;
				busWdata = {mode_reg, countDec};
				busWr = 1'b1;
			end
			dtvf_pkg::ST_WB2: begin
				busAddr = infoAddr + dtvf_pkg::INFO_OFF_SRC;
				busWdata = srcNext;
				busWr = 1'b1;
			end
			dtvf_pkg::ST_WB3: begin
				busAddr = infoAddr + dtvf_pkg::INFO_OFF_DST;
				busWdata = dstNext;
				busWr = 1'b1;
			end
			default: busWr = 1'b0;
		endcase
	end
	// Register read selection
	logic [31:0] rdSel; // Value for the addressed register
	always_comb begin
		rdSel = 32'h0000_0000;
		case (regAddr)
			dtvf_pkg::REG_ENA_LO: rdSel = enable_reg[NHW-2:0];
			dtvf_pkg::REG_ENA_HI: rdSel = {31'h0000_0000, enable_reg[NHW-1]};
			dtvf_pkg::REG_SWCTL: rdSel = {22'h00_0000, addrErr_reg, swEn_reg, swVec_reg};
			dtvf_pkg::REG_BASE: rdSel = {16'h0000, infoBase_reg};
			dtvf_pkg::REG_STAT: rdSel = {18'h0_0000, cur_reg, 7'h00, busy_reg};
			default: rdSel = 32'h0000_0000;
		endcase
	end
	// ************************************************************
	// Control registers
	// ************************************************************
	// Software-visible control and accepted activations
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			enable_reg <= dtvf_pkg::ENA_RST;
			swVec_reg <= dtvf_pkg::SWVEC_RST;
			swEn_reg <= 1'b0;
			addrErr_reg <= 1'b0;
			infoBase_reg <= dtvf_pkg::BASE_RST;
			pend_reg <= '0;
		end else begin
			enable_reg <= enable_next;
			swVec_reg <= swVec_next;
			swEn_reg <= swEn_next;
			addrErr_reg <= addrErr_next;
			infoBase_reg <= wrBase ? regWdata[15:0] : infoBase_reg;
			pend_reg <= pend_next;
		end
	end
	// Sequencer state and the source it serves
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= dtvf_pkg::ST_IDLE;
			cur_reg <= '0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cur_reg <= grantTake ? grantIdx : cur_reg;
			busy_reg <= (state_next != dtvf_pkg::ST_IDLE);
		end
	end
	// ************************************************************
	// Bus master and fetched information
	// ************************************************************
	// Request held until acknowledged; fields frozen meanwhile
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			memReq_reg <= 1'b0;
			memWr_reg <= 1'b0;
			memAddr_reg <= 32'h0000_0000;
			memSize_reg <= dtvf_pkg::SIZE_BYTE;
			memWdata_reg <= 32'h0000_0000;
		end else if (issue) begin
			memReq_reg <= 1'b1;
			memWr_reg <= busWr;
			memAddr_reg <= busAddr;
			memSize_reg <= busSize;
			memWdata_reg <= busWdata;
		end else if (memAck) begin
			memReq_reg <= 1'b0;
		end
	end
	// Capture read data for the state that asked for it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			vecEntry_reg <= 16'h0000;
			mode_reg <= 16'h0000;
			count_reg <= 16'h0000;
			srcAddr_reg <= 32'h0000_0000;
			dstAddr_reg <= 32'h0000_0000;
			data_reg <= 32'h0000_0000;
		end else if (memAck && memReq_reg) begin
			case (state_reg)
				dtvf_pkg::ST_VEC: vecEntry_reg <= memRdata[15:0];
				dtvf_pkg::ST_INF0: begin
					mode_reg <= memRdata[31:16];
					count_reg <= memRdata[15:0];
				end
				dtvf_pkg::ST_INF2: srcAddr_reg <= memRdata;
				dtvf_pkg::ST_INF3: dstAddr_reg <= memRdata;
				dtvf_pkg::ST_DRD: data_reg <= memRdata;
				default: data_reg <= data_reg;
			endcase
		end
	end
	// Read data only in the cycle after the strobe
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			regRdata_reg <= 32'h0000_0000;
			cpuIrq_reg <= '0;
			swIrq_reg <= 1'b0;
		end else begin
			regRdata_reg <= regRd ? rdSel : 32'h0000_0000;
			cpuIrq_reg <= (srcReq & ~enable_reg) | passMask[NHW-1:0]; // [R17] [R14]
			swIrq_reg <= doneSw && passIrq; // [R18]
		end
	end
	assign regRdata = regRdata_reg;
	assign cpuIrq = cpuIrq_reg;
	assign swIrq = swIrq_reg;
	assign memReq = memReq_reg;
	assign memWr = memWr_reg;
	assign memAddr = memAddr_reg;
	assign memSize = memSize_reg;
	assign memWdata = memWdata_reg;
	assign busy = busy_reg;
	// ************************************************************
	// Checks
	// ************************************************************
	vec_addr_hw_a: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
		(state_reg == dtvf_pkg::ST_VEC) && memReq_reg && !curIsSw
		|-> (memAddr_reg == dtvf_pkg::VEC_BASE + 32'(cur_reg) * 2)
			&& (memAddr_reg <= dtvf_pkg::VEC_LAST))
		else $error("hardware vector address wrong");
	vec_addr_sw_a: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
		(state_reg == dtvf_pkg::ST_VEC) && memReq_reg && curIsSw
		|-> memAddr_reg == dtvf_pkg::VEC_BASE + 32'(swVec_reg))
		else $error("software vector address wrong");
	info_base_a: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
		(state_reg == dtvf_pkg::ST_INF0) && memReq_reg
		|-> memAddr_reg == {infoBase_reg, vecEntry_reg})
		else $error("info address not base plus vector");
	fetch_order_a: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
		$changed(state_reg) && (state_reg == dtvf_pkg::ST_INF0)
		|-> $past(state_reg) == dtvf_pkg::ST_VEC)
		else $error("info read before vector read");
	count_wb_a: assert property (@(posedge clk_sys) disable iff (rst) // [R15]
		(state_reg == dtvf_pkg::ST_WB0) && memReq_reg
		|-> memWr_reg && (memWdata_reg == {mode_reg, count_reg - 16'h0001}))
		else $error("mode or count write-back wrong");
	one_unit_a: assert property (@(posedge clk_sys) disable iff (rst) // [R12]
		(state_reg == dtvf_pkg::ST_DWR) && memReq_reg
		|-> (memSize_reg == modeSize) && (memAddr_reg == dstAddr_reg))
		else $error("unit size or destination wrong");
	src_step_a: assert property (@(posedge clk_sys) disable iff (rst) // [R20]
		(state_reg == dtvf_pkg::ST_WB2) && memReq_reg && (modeSrc == dtvf_pkg::STEP_INC)
		|-> memWdata_reg == srcAddr_reg + (32'h0000_0001 << modeSize))
		else $error("source not stepped by unit size");
	last_irq_a: assert property (@(posedge clk_sys) disable iff (rst) // [R14]
		doneHw && lastXfer |=> cpuIrq_reg[cur_reg] && !enable_reg[cur_reg])
		else $error("last transfer did not interrupt and disable");
	skip_empty_a: assert property (@(posedge clk_sys) disable iff (rst) // [R21]
		memReq_reg && memWr_reg && (state_reg != dtvf_pkg::ST_DWR)
		|-> memAddr_reg != infoAddr + dtvf_pkg::INFO_OFF_THIRD)
		else $error("empty bytes rewritten");
endmodule
`default_nettype wire

// *** tb/dtvf_mem_model.sv ***
// Behavioural memory behind the transfer engine bus.
// Assumes big-endian bytes and one access at a time.
`timescale 1ns/1ps
`default_nettype none
module dtvf_mem_model (
	input wire logic clk_sys,
	input wire logic memReq,
	input wire logic memWr,
	input wire logic [31:0] memAddr,
	input wire logic [1:0] memSize,
	input wire logic [31:0] memWdata,
	input wire logic [3:0] waitCycles,
	output logic [31:0] memRdata,
	output logic memAck
);
	logic [7:0] mem [logic [31:0]]; // Sparse byte store
	logic [31:0] vecLog [$]; // Vector table reads, in order
	logic [3:0] waitCnt = 4'h0; // Latency counter
	int n; // Bytes in this access
	initial memAck = 1'b0;
	initial memRdata = 32'h0000_0000;
	// Big-endian read of k bytes, right-justified
	function automatic logic [31:0] rd(input logic [31:0] a, input int k);
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int i = 0; i < k; i++) v = {v[23:0], mem.exists(a + i) ? mem[a + i] : 8'h00};
		return v;
	endfunction
	// Data churns outside the ack cycle so stale values never look valid
	always @(posedge clk_sys) begin
		n = 1 << memSize;
		memRdata <= ~memRdata;
		memAck <= 1'b0;
		if (memReq && !memAck) begin
			waitCnt <= waitCnt + 4'h1;
			if (waitCnt == waitCycles) begin
				waitCnt <= 4'h0;
				memAck <= 1'b1;
				if (memWr) begin
					for (int i = 0; i < n; i++) mem[memAddr + i] = memWdata[8*(n-1-i) +: 8];
				end else begin
					memRdata <= rd(memAddr, n);
					if (memAddr[31:8] == 24'h00_0004) vecLog.push_back(memAddr);
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the vector fetch engine.
// Assumes the memory model answers every access.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0000_0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [32:0] srcReq = 33'h0_0000_0000;
	logic [3:0] waitCycles = 4'h3; // Slow memory first
	logic [31:0] regRdata, memAddr, memWdata, memRdata, rv;
	logic [32:0] cpuIrq;
	logic [33:0] irqSeen; // Interrupts seen during a run
	logic swIrq, memReq, memWr, memAck, busy;
	logic [1:0] memSize;
	int n_mismatch = 0;
	int n_compared = 0;
	always #5 clk_sys = ~clk_sys;
	dtvf_top DUT (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .srcReq(srcReq), .cpuIrq(cpuIrq),
		.swIrq(swIrq), .memReq(memReq), .memWr(memWr), .memAddr(memAddr), .memSize(memSize),
		.memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .busy(busy));
	dtvf_mem_model mem (.clk_sys(clk_sys), .memReq(memReq), .memWr(memWr), .memAddr(memAddr),
		.memSize(memSize), .memWdata(memWdata), .waitCycles(waitCycles), .memRdata(memRdata),
		.memAck(memAck));
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic regW(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic regR(input logic [7:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 rv = regRdata;
	endtask
	task automatic put(input logic [31:0] a, input logic [31:0] v, input int k);
		for (int i = 0; i < k; i++) mem.mem[a + i] = v[8*(k-1-i) +: 8];
	endtask
	// Transfer info: start addresses kept four-aligned by software
	task automatic info(input logic [31:0] a, input logic [31:0] head, input logic [31:0] s,
		input logic [31:0] d);
		put(a, head, 4);
		put(a + 4, 32'hA5A5_A5A5, 4);
		put(a + 8, s, 4);
		put(a + 12, d, 4);
	endtask
	// One-cycle request pulse, then bounded wait for idle
	task automatic run(input logic [32:0] req);
		int k;
		@(posedge clk_sys);
		srcReq <= req;
		@(posedge clk_sys);
		srcReq <= 33'h0_0000_0000;
		irqSeen = 34'h0;
		for (k = 0; k < 400 && !(k > 4 && busy === 1'b0); k++) begin
			@(posedge clk_sys);
			#1 irqSeen = irqSeen | {swIrq, cpuIrq};
		end
		repeat (3) begin
			@(posedge clk_sys);
			#1 irqSeen = irqSeen | {swIrq, cpuIrq};
		end
		if (k == 400) begin
			n_mismatch++;
			test_done();
		end
	endtask
	// Last hardware entry, word inc/dec, count one, slow memory
	task automatic test_last;
		regW(8'h0C, 32'h0000_0001);
		regW(8'h04, 32'h0000_0001);
		put(32'h440, 32'h2000, 2);
		info(32'h1_2000, 32'h0025_0001, 32'h3000, 32'h3100);
		put(32'h3000, 32'hBEEF, 2);
		run(33'h1_0000_0000);
		check(mem.rd(32'h1_2000, 4), 32'h0025_0000);
		check(mem.rd(32'h1_2004, 4), 32'hA5A5_A5A5);
		check(mem.rd(32'h1_2008, 4), 32'h3002);
		check(mem.rd(32'h1_200C, 4), 32'h30FE);
		check(mem.rd(32'h3100, 2), 32'hBEEF);
		check({31'h0, irqSeen[32]}, 32'h1);
		regR(8'h04);
		check(rv, 32'h0);
		@(posedge clk_sys);
		srcReq <= 33'h1_0000_0000;
		@(posedge clk_sys);
		srcReq <= 33'h0_0000_0000;
		#1 check({busy, cpuIrq[32]}, 32'h1);
		$display("test last entry done");
	endtask
	// First entry, byte fixed, count zero means full range
	task automatic test_full;
		waitCycles = 4'h0;
		regW(8'h00, 32'h0000_0001);
		put(32'h400, 32'h2040, 2);
		info(32'h1_2040, 32'h0000_0000, 32'h3200, 32'h3300);
		put(32'h3200, 32'h5A, 1);
		run(33'h0_0000_0001);
		check(mem.rd(32'h1_2040, 4), 32'h0000_FFFF);
		check(mem.rd(32'h1_2048, 4), 32'h3200);
		check(mem.rd(32'h3300, 1), 32'h5A);
		check({31'h0, irqSeen[0]}, 32'h0);
		regR(8'h00);
		check(rv, 32'h1);
		$display("test full count done");
	endtask
	// Software activation, interrupt on every transfer
	task automatic test_software;
		put(32'h410, 32'h2080, 2);
		info(32'h1_2080, 32'h0110_0005, 32'h3400, 32'h3500);
		put(32'h3400, 32'h77, 1);
		regW(8'h08, 32'h0000_0110);
		run(33'h0_0000_0000);
		check(mem.rd(32'h1_2080, 4), 32'h0110_0004);
		check(mem.rd(32'h1_208C, 4), 32'h3501);
		check({31'h0, irqSeen[33]}, 32'h1);
		regR(8'h08);
		check(rv, 32'h0000_0110);
		regR(8'h20);
		check(rv, 32'h0);
		$display("test software done");
	endtask
	// Two sources at once: table order decides
	task automatic test_priority;
		regW(8'h00, 32'h0000_0006);
		put(32'h402, 32'h20C0, 2);
		put(32'h404, 32'h20C0, 2);
		info(32'h1_20C0, 32'h0000_000A, 32'h3600, 32'h3700);
		mem.vecLog.delete();
		run(33'h0_0000_0006);
		run(33'h0_0000_0000);
		check(mem.vecLog[0], 32'h402);
		check(mem.vecLog[1], 32'h404);
		check(mem.rd(32'h1_20C0, 4), 32'h0000_0008);
		$display("test priority done");
	endtask
	// Misaligned start address: abort, flag, block, then clear
	task automatic test_addr_err;
		regW(8'h00, 32'h0000_0008);
		put(32'h406, 32'h2102, 2);
		run(33'h0_0000_0008);
		regR(8'h08);
		check(rv, 32'h0000_0310);
		regR(8'h10);
		check(rv, 32'h0000_0300);
		mem.vecLog.delete();
		run(33'h0_0000_0008);
		check(mem.vecLog.size(), 32'h0);
		regW(8'h08, 32'h0000_0110);
		regR(8'h08);
		check(rv, 32'h0000_0110);
		$display("test address error done");
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		test_last();
		test_full();
		test_software();
		test_priority();
		test_addr_err();
		test_done();
	end
endmodule
`default_nettype wire
